// file: include/core_regs_consts.svh
// Addresses, field positions and reset values of the core registers
`ifndef CORE_REGS_CONSTS_SVH
`define CORE_REGS_CONSTS_SVH
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_MEMORY_CONFIG 8'hAF
`define ADDR_STACK_POINTER_HIGH 8'hB7
`define ADDR_CPU_STATUS_WORD 8'hD0
`define ADDR_STACK_POINTER 8'h81
`define ADDR_DATA_POINTER_LOW 8'h82
`define ADDR_DATA_POINTER_HIGH 8'h83
`define ADDR_DATA_POINTER_PAGE 8'h84
`define RESET_BYTE 8'h00
`define RESET_STACK_POINTER 8'h07
`define RESET_SP_HIGH 3'h0
`define BIT_BAUD_DOUBLER 3'h7
`define BIT_SERIAL_WAKE 3'h6
`define BIT_IRQ0_WAKE 3'h5
`define BIT_LATCH_OFF 3'h4
`define BIT_POWERDOWN 3'h1
`define BIT_EXT_STACK 3'h7
`define BIT_XDATA_MAP 3'h0
`define POWER_CONTROL_STORED_MASK 8'hFC
`define CFG_STORED_MASK 8'h81
`define XDATA_MAP_TOP 24'h0007FF
`define STACK_XDATA_BASE 11'h100
`define DATA_POINTER_ONE 24'h000001
`define SP_ONE 11'h001
`define ZERO_BYTE 8'h00
`endif

// file: include/core_regs_pkg.sv
// Types for the core pointer and status register block
package core_regs_pkg;
  typedef struct packed {
    logic [7:0] dp_page;
    logic [7:0] dp_high;
    logic [7:0] dp_low;
    logic [7:0] sp_low;
    logic [2:0] sp_high;
    logic [7:0] status_word;
    logic [7:0] power_ctl;
    logic [7:0] mem_cfg;
    logic powerdown;
    logic irq0_sync1;
    logic irq0_sync2;
    logic irq0_sync3;
    logic irq0_level;
  } regs_state_t;
  typedef struct packed {
    logic [2:0] sync;
    logic level;
  } wake_state_t;
endpackage

// file: core/wake_sync.sv
// Three-stage input synchroniser with agreement filter
`include "core_regs_consts.svh"
module wake_sync (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_level
);
  core_regs_pkg::wake_state_t state;
  core_regs_pkg::wake_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.sync = {state.sync[1:0], i_pin};
    // Change counts once stages two and three agree
    if (state.sync[1] == state.sync[2]) begin
      next_state.level = state.sync[2];
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= '{sync: 3'h7, level: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign o_level = state.level;
endmodule

// file: core/core_pointer_status_regs.sv
// Data pointer, stack pointer, status word and power/memory config
`include "core_regs_consts.svh"
module core_pointer_status_regs (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_sfr_write,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_bit_write,
  input wire logic [2:0] i_bit_index,
  input wire logic i_bit_value,
  input wire logic i_data_pointer_inc,
  input wire logic i_data_pointer_load16,
  input wire logic [15:0] i_data_pointer_wdata,
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic i_flags_write,
  input wire logic [7:0] i_flags_mask,
  input wire logic [7:0] i_flags_value,
  input wire logic i_serial_irq,
  input wire logic i_ext_irq0_pin,
  input wire logic i_ext_irq0_edge_select,
  output logic [23:0] o_data_pointer,
  output logic [10:0] o_stack_pointer,
  output logic [10:0] o_stack_write_addr,
  output logic o_stack_in_xdata,
  output logic [7:0] o_cpu_status_word,
  output logic [1:0] o_bank_select,
  output logic o_baud_doubler,
  output logic o_latch_strobe_off,
  output logic o_powerdown,
  output logic o_wake,
  output logic o_gen_flag_one,
  output logic o_gen_flag_zero,
  output logic o_onchip_xdata_map_enable,
  output logic o_ext_stack_enable,
  output logic o_data_pointer_to_onchip,
  output logic o_xdata_space_24bit
);
  core_regs_pkg::regs_state_t state;
  core_regs_pkg::regs_state_t next_state;
  logic irq0_level;
  logic ext_stack;
  logic [10:0] sp_full;
  logic [10:0] sp_inc;
  logic [10:0] sp_dec;
  logic [23:0] data_pointer_inc;
  logic irq0_wake;
  logic serial_wake;
  logic [7:0] read_mux;
  logic hit;

  wake_sync u_irq0_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_pin(i_ext_irq0_pin),
    .o_level(irq0_level)
  );

  assign ext_stack = state.mem_cfg[`BIT_EXT_STACK];
  assign sp_full = ext_stack ? {state.sp_high, state.sp_low}
                             : {`RESET_SP_HIGH, state.sp_low};
  assign sp_inc = ext_stack ? sp_full + `SP_ONE
                            : {`RESET_SP_HIGH, state.sp_low + 8'h01};
  assign sp_dec = ext_stack ? sp_full - `SP_ONE
                            : {`RESET_SP_HIGH, state.sp_low - 8'h01};
  assign data_pointer_inc = {state.dp_page, state.dp_high, state.dp_low}
                    + `DATA_POINTER_ONE;

  assign irq0_wake = state.power_ctl[`BIT_IRQ0_WAKE] &&
    (i_ext_irq0_edge_select ? (state.irq0_level && !irq0_level)
                            : !irq0_level);
  assign serial_wake = state.power_ctl[`BIT_SERIAL_WAKE] && i_serial_irq;

  always_comb begin
    hit = 1'b1;
    read_mux = `ZERO_BYTE;
    unique case (i_sfr_addr)
      `ADDR_DATA_POINTER_LOW: read_mux = state.dp_low;
      `ADDR_DATA_POINTER_HIGH: read_mux = state.dp_high;
      `ADDR_DATA_POINTER_PAGE: read_mux = state.dp_page;
      `ADDR_STACK_POINTER: read_mux = state.sp_low;
      `ADDR_STACK_POINTER_HIGH: begin
        read_mux = ext_stack ? {5'h00, state.sp_high} : `ZERO_BYTE;
        hit = ext_stack;
      end
      `ADDR_CPU_STATUS_WORD: read_mux = state.status_word;
      `ADDR_POWER_CONTROL: read_mux = state.power_ctl;
      `ADDR_MEMORY_CONFIG: read_mux = state.mem_cfg;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.irq0_level = irq0_level;
    next_state.irq0_sync1 = 1'b0;
    next_state.irq0_sync2 = 1'b0;
    next_state.irq0_sync3 = 1'b0;
    if (i_flags_write) begin
      next_state.status_word = (state.status_word & ~i_flags_mask) |
                               (i_flags_value & i_flags_mask);
    end
    if (i_stack_push) begin
      next_state.sp_low = sp_inc[7:0];
      if (ext_stack) begin
        next_state.sp_high = sp_inc[10:8];
      end
    end else if (i_stack_pop) begin
      next_state.sp_low = sp_dec[7:0];
      if (ext_stack) begin
        next_state.sp_high = sp_dec[10:8];
      end
    end
    if (i_data_pointer_load16) begin
      next_state.dp_high = i_data_pointer_wdata[15:8];
      next_state.dp_low = i_data_pointer_wdata[7:0];
    end else if (i_data_pointer_inc) begin
      next_state.dp_page = data_pointer_inc[23:16];
      next_state.dp_high = data_pointer_inc[15:8];
      next_state.dp_low = data_pointer_inc[7:0];
    end
    if (i_bit_write && i_sfr_addr == `ADDR_CPU_STATUS_WORD) begin
      next_state.status_word[i_bit_index] = i_bit_value;
    end
    if (i_sfr_write) begin
      unique case (i_sfr_addr)
        `ADDR_DATA_POINTER_LOW: next_state.dp_low = i_sfr_wdata;
        `ADDR_DATA_POINTER_HIGH: next_state.dp_high = i_sfr_wdata;
        `ADDR_DATA_POINTER_PAGE: next_state.dp_page = i_sfr_wdata;
        `ADDR_STACK_POINTER: next_state.sp_low = i_sfr_wdata;
        `ADDR_STACK_POINTER_HIGH: begin
          if (ext_stack) begin
            next_state.sp_high = i_sfr_wdata[2:0];
          end
        end
        `ADDR_CPU_STATUS_WORD: next_state.status_word = i_sfr_wdata;
        `ADDR_POWER_CONTROL: begin
          next_state.power_ctl = i_sfr_wdata & `POWER_CONTROL_STORED_MASK;
          if (i_sfr_wdata[`BIT_POWERDOWN]) begin
            next_state.powerdown = 1'b1;
          end
        end
        `ADDR_MEMORY_CONFIG:
          next_state.mem_cfg = i_sfr_wdata & `CFG_STORED_MASK;
        default: next_state.mem_cfg = next_state.mem_cfg;
      endcase
    end
    // Wake ends power-down unless the same cycle writes the power-down bit
    if (state.powerdown && (irq0_wake || serial_wake) &&
        !(i_sfr_write && i_sfr_addr == `ADDR_POWER_CONTROL &&
          i_sfr_wdata[`BIT_POWERDOWN])) begin
      next_state.powerdown = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= '{dp_page: `RESET_BYTE, dp_high: `RESET_BYTE,
                 dp_low: `RESET_BYTE,
                 sp_low: `RESET_STACK_POINTER, sp_high: `RESET_SP_HIGH,
                 status_word: `RESET_BYTE, power_ctl: `RESET_BYTE,
                 mem_cfg: `RESET_BYTE, powerdown: 1'b0,
                 irq0_sync1: 1'b0, irq0_sync2: 1'b0, irq0_sync3: 1'b0,
                 irq0_level: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign o_sfr_rdata = read_mux;
  assign o_sfr_hit = hit;
  assign o_data_pointer = {state.dp_page, state.dp_high, state.dp_low};
  assign o_stack_pointer = sp_full;
  assign o_stack_write_addr = sp_inc;
  assign o_stack_in_xdata = ext_stack && (sp_full >= `STACK_XDATA_BASE);
  assign o_cpu_status_word = state.status_word;
  assign o_bank_select = state.status_word[4:3];
  assign o_baud_doubler = state.power_ctl[`BIT_BAUD_DOUBLER];
  assign o_latch_strobe_off = state.power_ctl[`BIT_LATCH_OFF];
  assign o_powerdown = state.powerdown;
  assign o_wake = state.powerdown && (irq0_wake || serial_wake);
  assign o_gen_flag_one = state.power_ctl[3];
  assign o_gen_flag_zero = state.power_ctl[2];
  assign o_onchip_xdata_map_enable = state.mem_cfg[`BIT_XDATA_MAP];
  assign o_ext_stack_enable = ext_stack;
  assign o_data_pointer_to_onchip = state.mem_cfg[`BIT_XDATA_MAP] &&
    ({state.dp_page, state.dp_high, state.dp_low} <= `XDATA_MAP_TOP);
  assign o_xdata_space_24bit = !state.mem_cfg[`BIT_XDATA_MAP];
endmodule

// file: dv/core_regs_props_properties.sv
// Port checks for the core register block
module core_regs_props (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_sfr_write,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic o_sfr_hit,
  input wire logic i_data_pointer_inc,
  input wire logic i_data_pointer_load16,
  input wire logic i_stack_push,
  input wire logic i_serial_irq,
  input wire logic [23:0] o_data_pointer,
  input wire logic [10:0] o_stack_pointer,
  input wire logic [10:0] o_stack_write_addr,
  input wire logic o_stack_in_xdata,
  input wire logic [7:0] o_cpu_status_word,
  input wire logic [1:0] o_bank_select,
  input wire logic o_powerdown,
  input wire logic o_onchip_xdata_map_enable,
  input wire logic o_ext_stack_enable,
  input wire logic o_data_pointer_to_onchip
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  bank_mirror_a: assert property (
    o_bank_select == o_cpu_status_word[4:3]) else $error("bank");
  onchip_route_a: assert property (
    o_data_pointer_to_onchip == (o_onchip_xdata_map_enable &&
    o_data_pointer <= 24'h0007FF)) else $error("route");
  push_order_a: assert property (
    i_stack_push && !i_sfr_write |=>
    o_stack_pointer == $past(o_stack_write_addr)) else $error("push");
  data_pointer_carry_a: assert property (
    i_data_pointer_inc && !i_data_pointer_load16 && !i_sfr_write |=>
    o_data_pointer == $past(o_data_pointer) + 24'h1) else $error("inc");
  sph_lock_a: assert property (
    i_sfr_addr == 8'hB7 |-> o_sfr_hit == o_ext_stack_enable)
    else $error("sph");
  stack_xdata_a: assert property (
    o_stack_in_xdata == (o_ext_stack_enable &&
    o_stack_pointer >= 11'h100)) else $error("xstack");
  narrow_stack_a: assert property (
    !o_ext_stack_enable |-> o_stack_pointer[10:8] == 3'h0)
    else $error("narrow");
  pd_entry_a: assert property (
    i_sfr_write && i_sfr_addr == 8'h87 && i_sfr_wdata[1] &&
    !i_serial_irq |=> o_powerdown) else $error("pd");
endmodule

// file: dv/core_model.sv
// Processor core model issuing register requests
module core_model (
  input wire logic i_clock,
  output logic o_sw,
  output logic [7:0] o_a,
  output logic [7:0] o_d,
  output logic o_bw,
  output logic o_push,
  output logic o_pop,
  output logic o_inc,
  output logic o_ld
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_sw, o_a, o_d, o_bw, o_push, o_pop, o_inc, o_ld} = '0;
  // Kinds: 0 byte, 1 bit, 2 push, 3 pop, 4 inc, 5 load
  task automatic req(input int k, input logic [7:0] a, d);
    @(negedge i_clock);
    {o_a, o_d} = {a, d};
    case (k)
      0: o_sw = 1'b1;
      1: o_bw = 1'b1;
      2: o_push = 1'b1;
      3: o_pop = 1'b1;
      4: o_inc = 1'b1;
      default: o_ld = 1'b1;
    endcase
    @(negedge i_clock);
    {o_sw, o_bw, o_push, o_pop, o_inc, o_ld} = '0;
    {o_a, o_d} = ~{o_a, o_d};
  endtask
  task automatic look(input logic [7:0] a);
    @(negedge i_clock);
    o_a = a;
    #1;
  endtask
endmodule

// file: dv/test_core_pointer_status_regs.sv
// Self-checking bench for the core register block
module test_core_pointer_status_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic irq = 1'b0;
  logic pin = 1'b1;
  logic fw = 1'b0;
  logic [7:0] fm = 8'h00, fv = 8'h00;
  logic sw, bw, push, pop, inc, ld, hit, sx, pd, onc;
  logic [7:0] a, d, rd, cpu_status_word;
  logic [23:0] dp;
  logic [10:0] sp;
  logic [1:0] bank;
  wire [3:0] pb;
  int failures = 0;
  int cmp_count = 0;
  int seed = 32'hf7a0c992;
  int e_sp, e_psw;
  logic [7:0] ra [5] = '{8'h87, 8'hAF, 8'hD0, 8'h81, 8'hB7};
  logic [7:0] er [5] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h00};
  always #20 i_clock = ~i_clock;
  core_model i_core (.i_clock(i_clock), .o_sw(sw), .o_a(a), .o_d(d),
    .o_bw(bw), .o_push(push), .o_pop(pop), .o_inc(inc), .o_ld(ld));
  core_pointer_status_regs i_dut (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_sfr_write(sw), .i_sfr_addr(a), .i_sfr_wdata(d), .o_sfr_rdata(rd),
    .o_sfr_hit(hit), .i_bit_write(bw), .i_bit_index(d[3:1]),
    .i_bit_value(d[0]), .i_data_pointer_inc(inc), .i_data_pointer_load16(ld),
    .i_data_pointer_wdata({a, d}), .i_stack_push(push), .i_stack_pop(pop),
    .i_flags_write(fw), .i_flags_mask(fm), .i_flags_value(fv),
    .i_serial_irq(irq), .i_ext_irq0_pin(pin),
    .i_ext_irq0_edge_select(1'b0), .o_data_pointer(dp),
    .o_stack_pointer(sp), .o_stack_write_addr(), .o_stack_in_xdata(sx),
    .o_cpu_status_word(cpu_status_word), .o_bank_select(bank),
    .o_baud_doubler(pb[3]), .o_latch_strobe_off(pb[2]),
    .o_powerdown(pd), .o_wake(), .o_gen_flag_one(pb[1]),
    .o_gen_flag_zero(pb[0]), .o_onchip_xdata_map_enable(),
    .o_ext_stack_enable(), .o_data_pointer_to_onchip(onc),
    .o_xdata_space_24bit());
  task automatic chk_rd(input logic [7:0] ad, ex);
    i_core.look(ad);
    cmp_count++;
    if (rd !== ex) begin
      failures++;
      $display("[ERR] %0t read %h got %h", $time, ad, rd);
    end
  endtask
  task automatic chk_out(input logic [23:0] got, ex);
    cmp_count++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %0t output %h want %h", $time, got, ex);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    wrap_up;
  end
  initial begin
    repeat (8) @(negedge i_clock);
    i_resetn = 1'b1;
    foreach (ra[i]) chk_rd(ra[i], er[i]);
    e_sp = 8;
    i_core.req(2, 8'h00, 8'h00);
    chk_out(sp, e_sp);
    i_core.req(0, 8'h81, 8'hFF);
    i_core.req(0, 8'hB7, 8'h05);
    i_core.req(2, 8'h00, 8'h00);
    chk_out({hit, sp}, 12'h000);
    chk_rd(8'hB7, 8'h00);
    i_core.req(0, 8'hAF, 8'hFF);
    chk_rd(8'hAF, 8'h81);
    i_core.req(0, 8'h81, 8'hFF);
    i_core.req(2, 8'h00, 8'h00);
    chk_out({sx, sp}, 12'h900);
    chk_rd(8'hB7, 8'h01);
    i_core.req(5, 8'hFF, 8'hFF);
    i_core.req(4, 8'h00, 8'h00);
    chk_out({onc, dp}, 25'h0010000);
    chk_rd(8'h84, 8'h01);
    i_core.req(0, 8'h84, 8'h00);
    i_core.req(5, 8'h07, 8'hFF);
    chk_out({onc, dp}, 25'h10007FF);
    repeat (4) begin
      e_psw = $random(seed) & 8'hFF;
      i_core.req(0, 8'hD0, e_psw[7:0]);
      chk_rd(8'hD0, e_psw[7:0]);
      chk_out(bank, e_psw[4:3]);
      e_psw[3] = ~e_psw[3];
      i_core.req(1, 8'hD0, {4'h0, 3'h3, e_psw[3]});
      chk_out(cpu_status_word, e_psw[7:0]);
      @(negedge i_clock);
      {fw, fm, fv} = {1'b1, 16'($random(seed))};
      @(negedge i_clock);
      fw = 1'b0;
      e_psw = (e_psw & ~fm) | (fv & fm);
      chk_out(cpu_status_word, e_psw[7:0]);
    end
    i_core.req(0, 8'h87, 8'hFF);
    chk_rd(8'h87, 8'hFC);
    chk_out({pd, pb}, 5'h1F);
    irq = 1'b1;
    for (int n = 0; n < 8 && pd !== 1'b0; n++) @(negedge i_clock);
    chk_out(pd, 1'b0);
    irq = 1'b0;
    i_core.req(0, 8'h87, 8'h22);
    chk_out(pd, 1'b1);
    pin = 1'b0;
    for (int n = 0; n < 8 && pd !== 1'b0; n++) @(negedge i_clock);
    chk_out(pd, 1'b0);
    pin = 1'b1;
    repeat (4) @(negedge i_clock);
    i_resetn = 1'b0;
    @(negedge i_clock);
    i_resetn = 1'b1;
    foreach (ra[i]) chk_rd(ra[i], er[i]);
    wrap_up;
  end
endmodule
bind core_pointer_status_regs core_regs_props i_props (.*);
